// ==== gp_rom_regs.sv ====
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`include "gp_rom_defines.svh"

module gp_rom_regs (
	input wire logic clock,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	input wire logic [7:0] gpio_in,
	output logic [7:0] gpio_out,
	output logic [7:0] gpio_oe,
	output logic rom_req,
	output logic rom_write,
	output logic [10:0] rom_addr,
	output logic [15:0] rom_wdata,
	output logic rom_preload_en,
	input wire logic rom_done,
	input wire logic [15:0] rom_rdata
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] pin_level_reg;
	logic [7:0] pin_dir_reg;
	logic [7:0] pin_val_reg;
	logic start_reg;
	logic preload_reg;
	logic [1:0] cmd_reg;
	logic [10:0] waddr_reg;
	logic [15:0] wbuf_reg;
	logic [15:0] fetched_reg;
	logic [31:0] rd_data_reg;
	logic req_reg;
	logic write_reg;
	logic [10:0] rom_addr_reg;
	logic [15:0] rom_wdata_reg;
	gp_rom_pkg::rom_state_t state_reg;
	logic [31:0] read_mux;
	logic cmd_valid;
	logic launch;
	logic finish;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	logic wr_gpio;
	logic wr_rom;
	assign wr_gpio = wr_en && (addr == `OFF_GPIO);
	assign wr_rom = wr_en && (addr == `OFF_ROM_CTL);
	assign cmd_valid = (cmd_reg == gp_rom_pkg::CMD_WRITE) || (cmd_reg == gp_rom_pkg::CMD_READ);
	assign launch = (state_reg == gp_rom_pkg::ST_IDLE) && start_reg && cmd_valid;
	assign finish = (state_reg == gp_rom_pkg::ST_BUSY) && rom_done;

	// ----------------------------------------
	// General purpose pins
	// ----------------------------------------
	// pin sampling
	always_ff @(posedge clock) begin
		if (rst) begin
			pin_level_reg <= `ZERO8;
		end else begin
			pin_level_reg <= gpio_in;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pin_dir_reg <= `ZERO8;
		end else if (wr_gpio) begin
			pin_dir_reg <= wr_data[`GPIO_DIR_R];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pin_val_reg <= `ZERO8;
		end else if (wr_gpio) begin
			pin_val_reg <= wr_data[`GPIO_OUT_R];
		end
	end

	// drive only outputs; the level alone is harmless when not enabled
	assign gpio_oe = pin_dir_reg;
	assign gpio_out = pin_val_reg;

	// ----------------------------------------
	// Serial ROM control fields
	// ----------------------------------------
	// start, set wins over done
	always_ff @(posedge clock) begin
		if (rst) begin
			start_reg <= 1'b0;
		end else if (wr_rom && wr_data[`ROM_START_B]) begin
			start_reg <= 1'b1;
		end else if (wr_rom) begin
			// A zero written as the cycle ends must not re-arm a second launch
			start_reg <= start_reg && (state_reg == gp_rom_pkg::ST_BUSY) && !finish;
		end else if (finish) begin
			start_reg <= 1'b0;
		end else if (start_reg && !cmd_valid && state_reg == gp_rom_pkg::ST_IDLE) begin
			start_reg <= 1'b0; // Reserved command: drop the start
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			preload_reg <= 1'b0;
		end else if (wr_rom) begin
			preload_reg <= wr_data[`ROM_PRELOAD_B];
		end
	end
	assign rom_preload_en = preload_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			cmd_reg <= `ZERO2;
			waddr_reg <= `ZERO11;
			wbuf_reg <= `ZERO16;
		end else if (wr_rom) begin
			cmd_reg <= wr_data[`ROM_CMD_R];
			waddr_reg <= wr_data[`ROM_ADDR_R];
			wbuf_reg <= wr_data[`ROM_DATA_R];
		end
	end

	// ----------------------------------------
	// Serial ROM access engine
	// ----------------------------------------
	// one cycle per start
	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= gp_rom_pkg::ST_IDLE;
		end else begin
			case (state_reg)
				gp_rom_pkg::ST_IDLE: begin
					if (launch) begin
						state_reg <= gp_rom_pkg::ST_BUSY;
					end
				end
				gp_rom_pkg::ST_BUSY: begin
					if (rom_done) begin
						state_reg <= gp_rom_pkg::ST_IDLE;
					end
				end
				default: begin
					state_reg <= gp_rom_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// latch operands at launch so later writes cannot disturb a cycle
	always_ff @(posedge clock) begin
		if (rst) begin
			req_reg <= 1'b0;
			write_reg <= 1'b0;
			rom_addr_reg <= `ZERO11;
			rom_wdata_reg <= `ZERO16;
		end else begin
			req_reg <= launch;
			if (launch) begin
				write_reg <= (cmd_reg == gp_rom_pkg::CMD_WRITE);
				rom_addr_reg <= waddr_reg;
				rom_wdata_reg <= wbuf_reg;
			end
		end
	end
	assign rom_req = req_reg;
	assign rom_write = write_reg;
	assign rom_addr = rom_addr_reg;
	assign rom_wdata = rom_wdata_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			fetched_reg <= `ZERO16;
		end else if (finish && !write_reg) begin
			fetched_reg <= rom_rdata;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Unmapped offsets and reserved bits read zero
	always_comb begin
		read_mux = `ZERO32;
		case (addr)
			`OFF_GPIO: begin
				read_mux[`GPIO_IN_R] = pin_level_reg;
				read_mux[`GPIO_DIR_R] = pin_dir_reg;
				read_mux[`GPIO_OUT_R] = pin_val_reg;
			end
			`OFF_ROM_CTL: begin
				read_mux[`ROM_START_B] = start_reg;
				read_mux[`ROM_PRELOAD_B] = preload_reg;
				read_mux[`ROM_CMD_R] = cmd_reg;
				read_mux[`ROM_ADDR_R] = waddr_reg;
				read_mux[`ROM_DATA_R] = wbuf_reg;
			end
			`OFF_CAP_HDR: begin
				read_mux[`CAP_ID_R] = `CAP_ID_VAL;
				read_mux[`CAP_NEXT_R] = `CAP_NEXT_VAL;
				read_mux[`CAP_VER_R] = `CAP_VER_VAL;
				read_mux[`CAP_TYPE_R] = `CAP_TYPE_VAL;
				read_mux[`CAP_SLOT_B] = `CAP_SLOT_VAL;
				read_mux[`CAP_MSG_R] = `CAP_MSG_VAL;
			end
			`OFF_DEV_CAP: begin
				read_mux[`DCAP_PAYLOAD_R] = `DCAP_PAYLOAD_VAL;
				read_mux[`DCAP_PHANTOM_R] = `DCAP_PHANTOM_VAL;
			end
			`OFF_ROM_RDATA: begin
				read_mux[`ROM_RDATA_R] = fetched_reg;
			end
			default: begin
				read_mux = `ZERO32;
			end
		endcase
	end

	// Data valid only in the cycle after the strobe
	always_ff @(posedge clock) begin
		if (rst) begin
			rd_data_reg <= `ZERO32;
		end else if (rd_en) begin
			rd_data_reg <= read_mux;
		end else begin
			rd_data_reg <= `ZERO32;
		end
	end
	assign rd_data = rd_data_reg;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_gpio_read;
		rd_en && (addr == `OFF_GPIO);
	endsequence

	sequence s_launch;
		(state_reg == gp_rom_pkg::ST_IDLE) && start_reg && cmd_valid;
	endsequence

	sequence s_req_pulse;
		rom_req ##1 !rom_req;
	endsequence

	property p_pin_level;
		s_gpio_read |=> rd_data[`GPIO_IN_R] == $past(gpio_in, 2);
	endproperty
	a_pin_level: assert property (p_pin_level) else $error("pin level read wrong");

	property p_input_undriven;
		wr_gpio |=> gpio_oe == $past(wr_data[`GPIO_DIR_R]);
	endproperty
	a_input_undriven: assert property (p_input_undriven) else $error("direction not applied");

	property p_out_kept;
		wr_gpio |=> gpio_out == $past(wr_data[`GPIO_OUT_R]);
	endproperty
	a_out_kept: assert property (p_out_kept) else $error("output value not kept");

	property p_dir_readback;
		s_gpio_read |=> rd_data[`GPIO_DIR_R] == gpio_oe;
	endproperty
	a_dir_readback: assert property (p_dir_readback) else $error("direction readback wrong");

	property p_launch;
		s_launch |=> s_req_pulse;
	endproperty
	a_launch: assert property (p_launch) else $error("start did not launch once");

	property p_no_reserved;
		rom_req |-> $past(cmd_valid);
	endproperty
	a_no_reserved: assert property (p_no_reserved) else $error("reserved command launched");

	property p_operands;
		s_launch |=> rom_addr == $past(waddr_reg) && rom_wdata == $past(wbuf_reg)
			&& rom_write == ($past(cmd_reg) == gp_rom_pkg::CMD_WRITE);
	endproperty
	a_operands: assert property (p_operands) else $error("operands not latched");

	property p_preload;
		wr_rom |=> rom_preload_en == $past(wr_data[`ROM_PRELOAD_B]);
	endproperty
	a_preload: assert property (p_preload) else $error("preload enable wrong");

	property p_cap_hdr;
		rd_en && (addr == `OFF_CAP_HDR) |=> rd_data == 32'h00110010;
	endproperty
	a_cap_hdr: assert property (p_cap_hdr) else $error("capability header wrong");

	property p_dev_cap;
		rd_en && (addr == `OFF_DEV_CAP) |=> rd_data[`DCAP_PAYLOAD_R] == `DCAP_PAYLOAD_VAL;
	endproperty
	a_dev_cap: assert property (p_dev_cap) else $error("device capabilities wrong");

	property p_phantom;
		rd_en && (addr == `OFF_DEV_CAP) |=> rd_data[`DCAP_PHANTOM_R] == `DCAP_PHANTOM_VAL;
	endproperty
	a_phantom: assert property (p_phantom) else $error("phantom field wrong");

	property p_cap_zeros;
		rd_en && (addr == `OFF_CAP_HDR) |=> rd_data[`CAP_SLOT_B] == `CAP_SLOT_VAL
			&& rd_data[`CAP_MSG_R] == `CAP_MSG_VAL;
	endproperty
	a_cap_zeros: assert property (p_cap_zeros) else $error("hardwired zeros wrong");

	property p_fetch;
		finish && !write_reg |=> fetched_reg == $past(rom_rdata);
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetched word lost");

	property p_start_set;
		wr_rom && wr_data[`ROM_START_B] |=> start_reg;
	endproperty
	a_start_set: assert property (p_start_set) else $error("start not set");

	// a finished cycle leaves start clear unless rewritten
	property p_start_clear;
		finish && !(wr_rom && wr_data[`ROM_START_B]) |=> !start_reg;
	endproperty
	a_start_clear: assert property (p_start_clear) else $error("start not cleared");

	property p_cmd_field;
		wr_rom |=> cmd_reg == $past(wr_data[`ROM_CMD_R]);
	endproperty
	a_cmd_field: assert property (p_cmd_field) else $error("command not stored");

	property p_addr_field;
		wr_rom |=> waddr_reg == $past(wr_data[`ROM_ADDR_R]);
	endproperty
	a_addr_field: assert property (p_addr_field) else $error("word address not stored");

	property p_data_field;
		wr_rom |=> wbuf_reg == $past(wr_data[`ROM_DATA_R]);
	endproperty
	a_data_field: assert property (p_data_field) else $error("write buffer not stored");

endmodule // gp_rom_regs

// ==== gp_rom_defines.svh ====
`ifndef GP_ROM_DEFINES_SVH
`define GP_ROM_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_GPIO 8'hD8
`define OFF_ROM_CTL 8'hDC
`define OFF_CAP_HDR 8'hE0
`define OFF_DEV_CAP 8'hE4
`define OFF_ROM_RDATA 8'hF0

// ----------------------------------------
// Pin control fields
// ----------------------------------------
`define GPIO_IN_R 7:0
`define GPIO_DIR_R 15:8
`define GPIO_OUT_R 23:16

// ----------------------------------------
// Serial ROM control fields
// ----------------------------------------
`define ROM_START_B 0
`define ROM_PRELOAD_B 2
`define ROM_CMD_R 4:3
`define ROM_ADDR_R 15:5
`define ROM_DATA_R 31:16
`define ROM_RDATA_R 15:0

// ----------------------------------------
// Capability header fields and values
// ----------------------------------------
`define CAP_ID_R 7:0
`define CAP_NEXT_R 15:8
`define CAP_VER_R 19:16
`define CAP_TYPE_R 23:20
`define CAP_SLOT_B 24
`define CAP_MSG_R 29:25
`define CAP_ID_VAL 8'h10
`define CAP_NEXT_VAL 8'h00
`define CAP_VER_VAL 4'h1
`define CAP_TYPE_VAL 4'h1
`define CAP_SLOT_VAL 1'h0
`define CAP_MSG_VAL 5'h00

// ----------------------------------------
// Device capabilities fields and values
// ----------------------------------------
`define DCAP_PAYLOAD_R 2:0
`define DCAP_PHANTOM_R 4:3
`define DCAP_PAYLOAD_VAL 3'h0
`define DCAP_PHANTOM_VAL 2'h0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ZERO2 2'h0
`define ZERO8 8'h00
`define ZERO11 11'h000
`define ZERO16 16'h0000
`define ZERO32 32'h00000000

`endif

// ==== gp_rom_pkg.sv ====
package gp_rom_pkg;

	// Serial ROM operation command
	typedef enum logic [1:0] {
		CMD_RSV_LO = 2'h0,
		CMD_WRITE = 2'h1,
		CMD_READ = 2'h2,
		CMD_RSV_HI = 2'h3
	} rom_cmd_t;

	// Serial ROM access engine
	typedef enum logic {
		ST_IDLE,
		ST_BUSY
	} rom_state_t;

endpackage

// ==== gp_rom_partner.sv ====
`timescale 1ns/1ns
// ----------------
// Serial ROM model
// ----------------
module gp_rom_partner (
	input wire logic clock,
	input wire logic rst,
	input wire logic rom_req,
	input wire logic rom_write,
	input wire logic [10:0] rom_addr,
	input wire logic [15:0] rom_wdata,
	input wire logic slow,
	output logic rom_done,
	output logic [15:0] rom_rdata
);
	logic [15:0] mem [0:2047];
	logic [3:0] wait_reg;
	logic [15:0] last_reg;
	always_ff @(posedge clock) begin
		rom_done <= 1'b0;
		rom_rdata <= ~last_reg; // Garbage outside done, never a stale word
		if (rst) begin
			wait_reg <= 4'h0;
			last_reg <= 16'h0000;
		end else if (rom_req) begin
			wait_reg <= slow ? 4'h9 : 4'h1;
		end else if (wait_reg == 4'h1) begin
			wait_reg <= 4'h0;
			rom_done <= 1'b1;
			if (rom_write) begin
				mem[rom_addr] <= rom_wdata;
			end else begin
				rom_rdata <= mem[rom_addr];
				last_reg <= mem[rom_addr];
			end
		end else if (wait_reg != 4'h0) begin
			wait_reg <= wait_reg - 4'h1;
		end
	end
endmodule // gp_rom_partner

// ==== gpio_eeprom_pcie_cap_regs_tb_top.sv ====
`timescale 1ns/1ns
module gpio_eeprom_pcie_cap_regs_tb_top;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wr_data = 32'h00000000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [31:0] rd_data;
	logic [7:0] gpio_in;
	logic [7:0] gpio_out;
	logic [7:0] gpio_oe;
	logic rom_req;
	logic rom_write;
	logic [10:0] rom_addr;
	logic [15:0] rom_wdata;
	logic rom_preload_en;
	logic rom_done;
	logic [15:0] rom_rdata;
	logic [7:0] ext = 8'h3C;
	logic slow = 1'b0;
	logic [31:0] d;
	int errors = 0;
	int total_checks = 0;
	int req_cnt = 0;
	// ----------------
	// Clock, pins, units
	// ----------------
	always #2 clock = ~clock;
	// Driven pins win over the outside level
	assign gpio_in = (ext & ~gpio_oe) | (gpio_out & gpio_oe);
	// Count launch pulses
	always @(posedge clock) if (rom_req === 1'b1) req_cnt++;
	gp_rom_regs i_dut (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .gpio_in(gpio_in),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .rom_req(rom_req), .rom_write(rom_write),
		.rom_addr(rom_addr), .rom_wdata(rom_wdata), .rom_preload_en(rom_preload_en),
		.rom_done(rom_done), .rom_rdata(rom_rdata));
	gp_rom_partner i_rom (.clock(clock), .rst(rst), .rom_req(rom_req),
		.rom_write(rom_write), .rom_addr(rom_addr), .rom_wdata(rom_wdata), .slow(slow),
		.rom_done(rom_done), .rom_rdata(rom_rdata));
	// ----------------
	// Shared tasks
	// ----------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Bounded waits; running out ends the run
	task automatic wait_req();
		int n;
		for (n = 0; n < 20 && rom_req !== 1'b1; n++) @(posedge clock) #1;
		if (rom_req !== 1'b1) begin
			chk("launch wait", 32'h1, rom_req);
			print_verdict();
		end
	endtask
	task automatic wait_idle();
		int n;
		d = 32'h1;
		for (n = 0; n < 30 && d[0] !== 1'b0; n++) rd(8'hDC);
		if (d[0] !== 1'b0) begin
			chk("idle wait", 32'h0, d[0]);
			print_verdict();
		end
	endtask
	// ----------------
	// Scenarios
	// ----------------
	task automatic t_reset();
		rd(8'hDC);
		chk("rom ctl", 32'h0, d);
		wr(8'hE0, 32'hFFFFFFFF);
		rd(8'hE0);
		chk("cap hdr", {2'h0, 5'h00, 1'b0, 4'h1, 4'h1, 8'h00, 8'h10}, d);
		rd(8'hE4);
		chk("dev cap", 32'h0, {27'h0, d[4:0]});
		rd(8'h00);
		chk("unmapped", 32'h0, d);
		$display("test reset done");
	endtask
	task automatic t_gpio();
		wr(8'hD8, 32'hFF5A0F77);
		repeat (3) @(posedge clock);
		chk("pin oe", 32'h0F, gpio_oe);
		chk("pin out", 32'h5A, gpio_out);
		rd(8'hD8);
		chk("pin ctl", {16'h5A0F, (ext & 8'hF0) | 8'h0A}, d);
		wr(8'hD8, 32'h005A0000);
		ext <= 8'hC3;
		repeat (3) @(posedge clock);
		chk("pin oe off", 32'h0, gpio_oe);
		chk("pin out kept", 32'h5A, gpio_out);
		rd(8'hD8);
		chk("pin inputs", 32'h005A00C3, d);
		$display("test gpio done");
	endtask
	task automatic t_rom();
		wr(8'hDC, {16'hBEEF, 11'h7FF, 2'h1, 3'b001});
		wait_req();
		chk("rom wr cmd", 32'h1, rom_write);
		chk("rom addr", 32'h7FF, rom_addr);
		chk("rom wdata", 32'hBEEF, rom_wdata);
		wait_idle();
		chk("rom ctl kept", {16'hBEEF, 11'h7FF, 2'h1, 3'b000}, d);
		chk("one launch", 32'h1, req_cnt);
		slow <= 1'b1;
		wr(8'hDC, {16'h0000, 11'h7FF, 2'h2, 3'b001});
		wait_req();
		chk("rom rd cmd", 32'h0, rom_write);
		wait_idle();
		rd(8'hF0);
		chk("fetched", 32'hBEEF, d);
		for (int c = 0; c < 4; c += 3) begin
			wr(8'hDC, {16'h0000, 11'h001, 2'(c), 3'b101});
			repeat (4) @(posedge clock);
			rd(8'hDC);
			chk("reserved cmd", {16'h0000, 11'h001, 2'(c), 3'b100}, d);
			chk("no launch", 32'h2, req_cnt);
			chk("preload", 32'h1, rom_preload_en);
		end
		$display("test rom done");
	endtask
	// Reset in mid-run must bring written fields back to zero
	task automatic t_mid_reset();
		wr(8'hD8, 32'h00A5F000);
		wr(8'hDC, {16'h1234, 11'h155, 2'h0, 3'b100});
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		chk("oe after reset", 32'h0, gpio_oe);
		chk("out after reset", 32'h0, gpio_out);
		chk("preload after reset", 32'h0, rom_preload_en);
		rd(8'hDC);
		chk("rom ctl after reset", 32'h0, d);
		rd(8'hD8);
		chk("pin ctl after reset", {24'h0, ext}, d);
		$display("test mid reset done");
	endtask
	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_gpio();
		t_rom();
		t_mid_reset();
		print_verdict();
	end
endmodule // gpio_eeprom_pcie_cap_regs_tb_top
